/* File: acc_adc_ctrl.v */
// Contract
// - Start pulse low, high, low triggers exactly one conversion, or 16 in accumulate mode.
// - Busy high during conversion; low at end with result registers valid.
// - Power enable low switches converter circuitry off.
// - Channel codes 0100 to 1111 disconnect all external pins.
// - Accumulate bit and justify bit together set output format.
// - Interrupt only when global and converter enables are both high.
// - Twelve bit result, full scale FFF, step of reference over 4096.
// - One conversion is 4 sample plus 12 convert clock periods.
// - Accumulate mode sums 16 conversions into a 16-bit result.
// - Completion sets the converter interrupt request flag.
// - Busy sets as soon as a conversion is initiated.
`timescale 1ns/1ps
`default_nettype none
`include "acc_adc_regs.vh"

module acc_adc_ctrl
(
    input  wire                       sys_clk_i,
    input  wire                       rst_n_i,
    input  wire                       conv_power_enable_i,
    input  wire                       start_bit_i,
    input  wire [`ACC_DIV_SEL_W-1:0]  conv_clock_divider_sel_i,
    input  wire [2:0]                 input_source_sel_i,
    input  wire [3:0]                 external_channel_sel_i,
    input  wire [1:0]                 reference_source_sel_i,
    input  wire                       accumulate_mode_bit_i,
    input  wire                       result_justify_bit_i,
    input  wire                       global_irq_enable_i,
    input  wire                       conv_irq_enable_i,
    input  wire                       conv_irq_flag_clr_i,
    input  wire [`ACC_RES_W-1:0]      analog_code_i,
    output wire                       analog_power_o,
    output wire                       analog_sample_o,
    output wire [3:0]                 pin_channel_o,
    output wire                       pin_connect_o,
    output wire [2:0]                 analog_source_o,
    output wire [1:0]                 analog_reference_o,
    output wire                       conv_busy_flag_o,
    output wire                       conv_irq_flag_o,
    output wire                       irq_o,
    output wire [7:0]                 result_high_reg_o,
    output wire [7:0]                 result_low_reg_o
);

    ////////////////////////////////////////////////////////////////////////
    reg                       start_d_r;
    reg                       armed_r;
    reg  [1:0]                state_r;
    reg  [1:0]                state_nxt;
    reg  [4:0]                per_r;
    reg  [4:0]                rep_r;
    reg  [`ACC_SUM_W-1:0]     sum_r;
    reg                       accum_r;
    reg                       irq_flag_r;
    reg  [7:0]                res_hi_r;
    reg  [7:0]                res_lo_r;
    wire                      tick;
    wire                      trigger;
    wire                      running;
    wire [`ACC_SUM_W-1:0]     sum_add;
    wire                      finish;

    assign trigger = start_d_r && !start_bit_i && armed_r;
    assign running = (state_r == `ACC_ST_SAMPLE)
                  || (state_r == `ACC_ST_CONVERT);

    acc_clk_div u_div
    (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .run_i     (running),
        .sel_i     (conv_clock_divider_sel_i),
        .tick_o    (tick)
    );

    // Rising edge arms; falling edge with power on fires
    always @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            start_d_r <= 1'b0;
            armed_r   <= 1'b0;
        end
        else
        begin
            start_d_r <= start_bit_i;
            if (!conv_power_enable_i)
                armed_r <= 1'b0;
            else if (!start_d_r && start_bit_i)
                armed_r <= 1'b1;
            else if (trigger)
                armed_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            `ACC_ST_IDLE:
                if (trigger && conv_power_enable_i)
                    state_nxt = `ACC_ST_SAMPLE;
            `ACC_ST_SAMPLE:
                if (tick && per_r == `ACC_SAMPLE_PER - 5'h01)
                    state_nxt = `ACC_ST_CONVERT;
            `ACC_ST_CONVERT:
                if (tick && per_r == `ACC_TOTAL_PER - 5'h01)
                begin
                    if (accum_r && rep_r != `ACC_ACCUM_CNT - 5'h01)
                        state_nxt = `ACC_ST_SAMPLE;
                    else
                        state_nxt = `ACC_ST_DONE;
                end
            `ACC_ST_DONE:
                state_nxt = `ACC_ST_IDLE;
            default:
                state_nxt = `ACC_ST_IDLE;
        endcase
        if (!conv_power_enable_i)
            state_nxt = `ACC_ST_IDLE;
    end

    assign sum_add     = sum_r + {4'h0, analog_code_i};
    // Result and flag land on the edge at which busy drops
    assign finish      = (state_r == `ACC_ST_CONVERT)
                      && (state_nxt == `ACC_ST_DONE);

    always @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_r <= `ACC_ST_IDLE;
            per_r   <= 5'h00;
            rep_r   <= 5'h00;
            sum_r   <= 16'h0000;
            accum_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            if (state_r == `ACC_ST_IDLE)
            begin
                per_r   <= 5'h00;
                rep_r   <= 5'h00;
                sum_r   <= 16'h0000;
                accum_r <= accumulate_mode_bit_i;
            end
            else if (tick && running)
            begin
                if (per_r == `ACC_TOTAL_PER - 5'h01)
                begin
                    per_r <= 5'h00;
                    rep_r <= rep_r + 5'h01;
                    sum_r <= sum_add;
                end
                else
                    per_r <= per_r + 5'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result registers and request flag
    always @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            res_hi_r   <= 8'h00;
            res_lo_r   <= 8'h00;
            irq_flag_r <= 1'b0;
        end
        else
        begin
            if (finish)
            begin
                if (accum_r)
                begin
                    res_hi_r <= sum_add[15:8];
                    res_lo_r <= sum_add[7:0];
                end
                else if (result_justify_bit_i)
                begin
                    res_hi_r <= {4'h0, sum_add[11:8]};
                    res_lo_r <= sum_add[7:0];
                end
                else
                begin
                    res_hi_r <= sum_add[11:4];
                    res_lo_r <= {sum_add[3:0], 4'h0};
                end
            end
            if (finish)
                irq_flag_r <= 1'b1;
            else if (conv_irq_flag_clr_i)
                irq_flag_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // busy from initiation
    assign conv_busy_flag_o   = running;
    assign irq_o              = irq_flag_r && global_irq_enable_i
                             && conv_irq_enable_i;
    assign conv_irq_flag_o    = irq_flag_r;
    assign result_high_reg_o  = res_hi_r;
    assign result_low_reg_o   = res_lo_r;
    assign analog_power_o     = conv_power_enable_i;
    assign analog_sample_o    = (state_r == `ACC_ST_SAMPLE);
    assign pin_connect_o      = conv_power_enable_i
                             && (external_channel_sel_i < `ACC_CH_NONE_MIN);
    assign pin_channel_o      = external_channel_sel_i;
    assign analog_source_o    = input_source_sel_i;
    assign analog_reference_o = reference_source_sel_i;

endmodule
`default_nettype wire

/* File: acc_adc_regs.vh */
`ifndef ACC_ADC_REGS_VH
`define ACC_ADC_REGS_VH

// Result width and full scale
`define ACC_RES_W        12
`define ACC_FULL_SCALE   12'hFFF
`define ACC_SUM_W        16
// Conversion phases in converter clock periods
`define ACC_SAMPLE_PER   5'h04
`define ACC_TOTAL_PER    5'h10
`define ACC_CONV_PER     5'h0C
// Accumulation count
`define ACC_ACCUM_CNT    5'h10
// Divider
`define ACC_DIV_SEL_W    3
`define ACC_DIV_CNT_W    7
// Lowest channel code that is not an external pin
`define ACC_CH_NONE_MIN  4'h4
// States
`define ACC_ST_IDLE      2'h0
`define ACC_ST_SAMPLE    2'h1
`define ACC_ST_CONVERT   2'h2
`define ACC_ST_DONE      2'h3

`endif

/* File: acc_clk_div.v */
`timescale 1ns/1ps
`default_nettype none
`include "acc_adc_regs.vh"

module acc_clk_div
(
    input  wire                       sys_clk_i,
    input  wire                       rst_n_i,
    input  wire                       run_i,
    input  wire [`ACC_DIV_SEL_W-1:0]  sel_i,
    output wire                       tick_o
);

    reg  [`ACC_DIV_CNT_W-1:0] cnt_r;
    wire [`ACC_DIV_CNT_W-1:0] limit;

    assign limit  = (7'h01 << sel_i) - 7'h01;
    assign tick_o = run_i && (cnt_r >= limit);

    always @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cnt_r <= 7'h00;
        else if (!run_i || tick_o)
            cnt_r <= 7'h00;
        else
            cnt_r <= cnt_r + 7'h01;
    end

endmodule
`default_nettype wire

/* File: acc_adc_ctrl_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module acc_ctrl_monitor
(
    input wire logic        sys_clk_i,
    input wire logic        rst_n_i,
    input wire logic        conv_power_enable_i,
    input wire logic        start_bit_i,
    input wire logic [2:0]  conv_clock_divider_sel_i,
    input wire logic [3:0]  external_channel_sel_i,
    input wire logic        accumulate_mode_bit_i,
    input wire logic        global_irq_enable_i,
    input wire logic        conv_irq_enable_i,
    input wire logic        analog_power_o,
    input wire logic        analog_sample_o,
    input wire logic        pin_connect_o,
    input wire logic        conv_busy_flag_o,
    input wire logic        conv_irq_flag_o,
    input wire logic        irq_o,
    input wire logic [7:0]  result_high_reg_o,
    input wire logic [7:0]  result_low_reg_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////////////////////////////
    power_pass_a: assert property (
        analog_power_o == conv_power_enable_i) else $error("power out");
    power_off_a: assert property (
        !conv_power_enable_i |=> !conv_busy_flag_o) else $error("busy off");
    pin_cut_a: assert property (
        external_channel_sel_i >= 4'h4 |-> !pin_connect_o) else $error("pin");
    irq_gate_a: assert property (irq_o == (conv_irq_flag_o &&
        global_irq_enable_i && conv_irq_enable_i)) else $error("irq gate");
    busy_start_a: assert property ($rose(conv_busy_flag_o) |->
        !$past(start_bit_i) && $past(start_bit_i, 2)) else $error("start");
    busy_len_a: assert property ($rose(conv_busy_flag_o) &&
        conv_clock_divider_sel_i == 3'h0 && !accumulate_mode_bit_i |->
        conv_busy_flag_o[*8] ##1 conv_busy_flag_o[*8] ##1 !conv_busy_flag_o)
        else $error("busy length");
    sample_len_a: assert property ($rose(conv_busy_flag_o) &&
        conv_clock_divider_sel_i == 3'h0 |->
        analog_sample_o[*4] ##1 !analog_sample_o) else $error("sample");
    flag_set_a: assert property ($fell(conv_busy_flag_o) &&
        conv_power_enable_i |-> conv_irq_flag_o) else $error("flag set");
    result_hold_a: assert property ($changed({result_high_reg_o,
        result_low_reg_o}) |-> $fell(conv_busy_flag_o)) else $error("hold");
    cover property ($fell(conv_busy_flag_o));
    cover property (irq_o);
    cover property ($rose(conv_busy_flag_o) && accumulate_mode_bit_i);
endmodule
bind acc_adc_ctrl acc_ctrl_monitor i_mon (.*);
`default_nettype wire

/* File: test_adc_conversion_control.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin \
    mismatches++; $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module test_adc_conversion_control;
    logic        sys_clk_i, rst_n_i, conv_power_enable_i, start_bit_i;
    logic [2:0]  conv_clock_divider_sel_i, input_source_sel_i;
    logic [3:0]  external_channel_sel_i, pin_channel_o;
    logic [1:0]  reference_source_sel_i, analog_reference_o;
    logic        accumulate_mode_bit_i, result_justify_bit_i;
    logic        global_irq_enable_i, conv_irq_enable_i, conv_irq_flag_clr_i;
    logic [11:0] analog_code_i;
    logic        analog_power_o, analog_sample_o, pin_connect_o, irq_o;
    logic [2:0]  analog_source_o;
    logic        conv_busy_flag_o, conv_irq_flag_o;
    logic [7:0]  result_high_reg_o, result_low_reg_o;
    logic [31:0] rs = 32'h00011EB3;
    int          compares = 0, mismatches = 0, cyc = 0, n;
    logic [15:0] exp_q[$];
    logic [15:0] last;
    acc_adc_ctrl i_dut (.*);
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    task automatic step(input int k);
        repeat (k) @(negedge sys_clk_i);
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic conv(input logic [2:0] s, input logic j, a,
        input logic [11:0] c);
        step(1);
        {conv_clock_divider_sel_i, result_justify_bit_i} = {s, j};
        {accumulate_mode_bit_i, analog_code_i} = {a, c};
        {global_irq_enable_i, conv_irq_enable_i} = 2'(rnd());
        {start_bit_i, conv_irq_flag_clr_i} = 2'b11;
        step(1);
        {start_bit_i, conv_irq_flag_clr_i} = 2'b00;
        `CHK("flag clear", 1'b0, conv_irq_flag_o)
        // Left justified and sum of 16 equal codes share one layout
        exp_q.push_back((a || !j) ? {c, 4'h0} : {4'h0, c});
        n = 0;
        step(1);
        `CHK("sampling", 1'b1, analog_sample_o)
        while (conv_busy_flag_o === 1'b1 && n < 9000)
        begin
            n++;
            step(1);
        end
        `CHK("busy cycles", (a ? 256 : 16) << s, n)
        last = exp_q.pop_front();
        `CHK("result", last, {result_high_reg_o, result_low_reg_o})
        `CHK("flag set", 1'b1, conv_irq_flag_o)
        `CHK("irq", global_irq_enable_i & conv_irq_enable_i, irq_o)
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            close_out();
        end
    end
    initial
    begin
        {rst_n_i, conv_power_enable_i, start_bit_i} = 3'b000;
        {conv_clock_divider_sel_i, input_source_sel_i} = 6'h00;
        {external_channel_sel_i, reference_source_sel_i} = 6'h00;
        {accumulate_mode_bit_i, result_justify_bit_i} = 2'b00;
        {global_irq_enable_i, conv_irq_enable_i} = 2'b00;
        {conv_irq_flag_clr_i, analog_code_i} = 13'h0000;
        step(16);
        {rst_n_i, conv_power_enable_i} = 2'b11;
        for (int i = 0; i < 16; i++)
        begin
            step(1);
            {input_source_sel_i, reference_source_sel_i} = 5'(rnd());
            external_channel_sel_i = 4'(i);
            #1;
            `CHK("connect", 1'(i < 4), pin_connect_o)
            `CHK("channel", 4'(i), pin_channel_o)
            `CHK("source", input_source_sel_i, analog_source_o)
            `CHK("ref", reference_source_sel_i, analog_reference_o)
        end
        for (int s = 0; s < 7; s++)
            conv(3'(s), 1'(s), 1'b0, 12'(rnd()));
        conv(3'h7, 1'b1, 1'b0, 12'hFFF);
        conv(3'h0, 1'b0, 1'b1, 12'(rnd()));
        conv(3'h1, 1'b1, 1'b1, 12'hFFF);
        // Power drop in mid-conversion, then a pulse while unpowered
        conv_clock_divider_sel_i = 3'h2;
        {start_bit_i, conv_irq_flag_clr_i} = 2'b11;
        step(1);
        {start_bit_i, conv_irq_flag_clr_i} = 2'b00;
        step(10);
        `CHK("busy run", 1'b1, conv_busy_flag_o)
        conv_power_enable_i = 1'b0;
        step(1);
        `CHK("abort busy", 1'b0, conv_busy_flag_o)
        `CHK("power off", 1'b0, analog_power_o)
        start_bit_i = 1'b1;
        step(1);
        start_bit_i = 1'b0;
        step(70);
        `CHK("off busy", 1'b0, conv_busy_flag_o)
        `CHK("abort flag", 1'b0, conv_irq_flag_o)
        `CHK("abort result", last, {result_high_reg_o, result_low_reg_o})
        conv_power_enable_i = 1'b1;
        step(4);
        `CHK("no pulse", 1'b0, conv_busy_flag_o)
        close_out();
    end
endmodule
`default_nettype wire
